// ===== include/pin_sense_pkg.sv
package pin_sense_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_PINS = 32;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_OUT         = 12'h504;
  localparam logic [ADDR_W-1:0] OFS_OUTSET      = 12'h508;
  localparam logic [ADDR_W-1:0] OFS_OUTCLR      = 12'h50c;
  localparam logic [ADDR_W-1:0] OFS_IN          = 12'h510;
  localparam logic [ADDR_W-1:0] OFS_DIR         = 12'h514;
  localparam logic [ADDR_W-1:0] OFS_DIRSET      = 12'h518;
  localparam logic [ADDR_W-1:0] OFS_DIRCLR      = 12'h51c;
  localparam logic [ADDR_W-1:0] OFS_MATCH_LATCH = 12'h520;
  localparam logic [ADDR_W-1:0] OFS_MATCH_SRC   = 12'h524;
  localparam logic [ADDR_W-1:0] OFS_PIN_SETUP   = 12'h700;
  // pin_setup[n] sits at OFS_PIN_SETUP + 4*n; top bits select the block
  localparam logic [4:0]        PIN_SETUP_BLOCK = 5'h0e;

  // ****************************************************************
  // pin_setup field positions
  // ****************************************************************
  localparam int FLD_DIR      = 0;
  localparam int FLD_DISC     = 1;
  localparam int FLD_PULL_LO  = 2;
  localparam int FLD_ANALOG   = 4;
  localparam int FLD_DRIVE_LO = 8;
  localparam int FLD_SENSE_LO = 16;

  localparam logic [1:0] SENSE_OFF  = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW  = 2'h3;
  localparam logic [1:0] PULL_DOWN  = 2'h1;
  localparam logic [1:0] PULL_UP    = 2'h3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_OUT       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_DIR       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_PIN_SETUP = 32'h0000_0002;

  typedef enum logic {SRC_MERGED, SRC_LATCHED} match_src_e;

  typedef struct packed {
    logic [1:0] sense;
    logic [2:0] drive;
    logic       analog;
    logic [1:0] pull;
    logic       disc;
    logic       dir;
  } pin_setup_s;

endpackage

// ===== hdl/pin_level_sense_latch.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// RL1: up to 32 pins, each configured separately
// RL2: setup holds dir, drive, pulls, sense, disconnect, analog
// RL3: sense selects high or low level
// RL4: each pin raises its own match flag
// RL5: merged flags form the port match signal
// RL6: sensing works in active and off states
// RL7: already-true condition raises match at once
// RL8: port event only if match was low
// RL9: software parks pin at non-matching level first
// RL10: port match acts as wake source
// RL11: pin match sets same-position sticky bit
// RL12: clear ignored while match flag high
// RL13: sticky bit clears only by writing one
// RL14: latched match high while any bit set
// RL15: clear leaving bits set gives fresh edge
// RL16: sticky register readable in every mode
// RL17: selector picks merged or latched source
// RL18: disconnected buffer hides pin from input, sense
// RL19: peripherals override output, config; read input
// RL20: pin setup kept across low-power states
// RL21: pin inputs pass two-stage synchroniser
module pin_level_sense_latch
  import pin_sense_pkg::*;
#(
  parameter int PIN_COUNT = pin_sense_pkg::NUM_PINS
) (
  input  wire logic                                   CLK,
  input  wire logic                                   RST,
  input  wire logic                                   PSEL,
  input  wire logic                                   PENABLE,
  input  wire logic                                   PWRITE,
  input  wire logic [pin_sense_pkg::ADDR_W-1:0]       PADDR,
  input  wire logic [pin_sense_pkg::DATA_W-1:0]       PWDATA,
  input  wire logic [3:0]                             PSTRB,
  output logic      [pin_sense_pkg::DATA_W-1:0]       PRDATA,
  output logic                                        PREADY,
  output logic                                        PSLVERR,
  input  wire logic [PIN_COUNT-1:0]                   PIN_IN,
  output logic      [PIN_COUNT-1:0]                   PIN_OUT,
  output logic      [PIN_COUNT-1:0]                   PIN_OE_N,
  output logic      [PIN_COUNT-1:0]                   PIN_PULLUP_EN,
  output logic      [PIN_COUNT-1:0]                   PIN_PULLDOWN_EN,
  output logic      [PIN_COUNT-1:0][2:0]              PIN_DRIVE,
  output logic      [PIN_COUNT-1:0]                   PIN_BUF_DISC,
  output logic      [PIN_COUNT-1:0]                   PIN_ANALOG_EN,
  input  wire logic [PIN_COUNT-1:0]                   OVR_EN,
  input  wire logic [PIN_COUNT-1:0]                   OVR_OUT,
  input  wire logic [PIN_COUNT-1:0]                   OVR_DIR,
  input  wire logic [PIN_COUNT-1:0]                   OVR_ANALOG,
  output logic      [PIN_COUNT-1:0]                   PERIPH_IN,
  input  wire logic                                   SYS_OFF,
  output logic                                        PORT_MATCH,
  output logic                                        PORT_EVENT,
  output logic                                        WAKE_REQ
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic pin_setup_s setup_from_word(input logic [DATA_W-1:0] w);
    pin_setup_s s;
    s.dir    = w[FLD_DIR];
    s.disc   = w[FLD_DISC];
    s.pull   = w[FLD_PULL_LO +: 2];
    s.analog = w[FLD_ANALOG];
    s.drive  = w[FLD_DRIVE_LO +: 3];
    s.sense  = w[FLD_SENSE_LO +: 2];
    return s;
  endfunction

  function automatic logic [DATA_W-1:0] setup_to_word(input pin_setup_s s);
    logic [DATA_W-1:0] w;
    w                    = '0;
    w[FLD_DIR]           = s.dir;
    w[FLD_DISC]          = s.disc;
    w[FLD_PULL_LO +: 2]  = s.pull;
    w[FLD_ANALOG]        = s.analog;
    w[FLD_DRIVE_LO +: 3] = s.drive;
    w[FLD_SENSE_LO +: 2] = s.sense;
    return w;
  endfunction

  // partial words keep the lanes whose strobe is low
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w,
                                                    input logic [3:0]        strb);
    logic [DATA_W-1:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  pin_setup_s             setup_q [PIN_COUNT];
  logic [PIN_COUNT-1:0]   out_q;
  logic [PIN_COUNT-1:0]   dir_q;
  logic [PIN_COUNT-1:0]   latch_q;
  logic [PIN_COUNT-1:0]   latch_d;
  match_src_e             src_q;
  logic                   clr_seen_q;
  logic                   latched_match_signal_q;
  logic [PIN_COUNT-1:0]   pin_meta_q;
  logic [PIN_COUNT-1:0]   pin_sync_q;
  logic                   ready_q;
  logic [DATA_W-1:0]      prdata_q;
  logic                   pslverr_q;

  logic [PIN_COUNT-1:0]   connected;
  logic [PIN_COUNT-1:0]   det;
  logic [PIN_COUNT-1:0]   latch_clr;
  logic                   merged;
  logic                   port_match_d;
  logic                   acc_start;
  logic                   acc_done;
  logic                   wr_done;
  logic                   setup_hit;
  logic [4:0]             setup_idx;
  logic                   reg_hit;
  logic [DATA_W-1:0]      rd_word;

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= PIN_IN;     // RL21
      pin_sync_q <= pin_meta_q; // RL21
    end
  end

  // ****************************************************************
  // level sense
  // ****************************************************************
  // sensing ignores SYS_OFF on purpose: it must keep running while off
  always_comb begin
    det    = '0;
    merged = 1'b0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      connected[i] = ~setup_q[i].disc | OVR_EN[i]; // RL18 RL19
      case (setup_q[i].sense)
        SENSE_HIGH: det[i] = connected[i] & pin_sync_q[i];  // RL3 RL4 RL18
        SENSE_LOW:  det[i] = connected[i] & ~pin_sync_q[i]; // RL3 RL4 RL18
        default:    det[i] = 1'b0;
      endcase
    end
    merged = |det; // RL5 RL6
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // two-cycle access: pready rises in the second access cycle
  assign acc_start = PSEL & PENABLE & ~ready_q;
  assign acc_done  = PSEL & PENABLE & ready_q;
  assign wr_done   = acc_done & PWRITE & ~pslverr_q;
  assign setup_idx = PADDR[6:2];
  assign setup_hit = (PADDR[ADDR_W-1:7] == PIN_SETUP_BLOCK) && (PADDR[1:0] == 2'b00)
                     && (32'(setup_idx) < PIN_COUNT);

  always_comb begin
    rd_word = '0;
    reg_hit = 1'b1;
    if (setup_hit) begin
      rd_word = setup_to_word(setup_q[setup_idx]);
    end else begin
      case (PADDR)
        OFS_OUT, OFS_OUTSET, OFS_OUTCLR: rd_word = 32'(out_q);
        OFS_IN:          rd_word = 32'(pin_sync_q & connected); // RL18
        OFS_DIR, OFS_DIRSET, OFS_DIRCLR: rd_word = 32'(dir_q);
        OFS_MATCH_LATCH: rd_word = 32'(latch_q);                // RL16
        OFS_MATCH_SRC:   rd_word = 32'(src_q);
        default:         reg_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ready_q   <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      ready_q <= acc_start;
      if (acc_start) begin
        prdata_q  <= PWRITE ? '0 : rd_word;
        pslverr_q <= ~reg_hit;
      end else begin
        prdata_q  <= '0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // output and direction registers
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_q <= PIN_COUNT'(RST_OUT);
    end else if (wr_done) begin
      case (PADDR)
        OFS_OUT:    out_q <= PIN_COUNT'(merge_lanes(32'(out_q), PWDATA, PSTRB));
        OFS_OUTSET: out_q <= out_q | PIN_COUNT'(merge_lanes('0, PWDATA, PSTRB));
        OFS_OUTCLR: out_q <= out_q & ~PIN_COUNT'(merge_lanes('0, PWDATA, PSTRB));
        default:    out_q <= out_q;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dir_q <= PIN_COUNT'(RST_DIR);
    end else if (wr_done) begin
      if (setup_hit) begin
        dir_q[setup_idx] <= PSTRB[0] ? PWDATA[FLD_DIR] : dir_q[setup_idx];
      end else begin
        case (PADDR)
          OFS_DIR:    dir_q <= PIN_COUNT'(merge_lanes(32'(dir_q), PWDATA, PSTRB));
          OFS_DIRSET: dir_q <= dir_q | PIN_COUNT'(merge_lanes('0, PWDATA, PSTRB));
          OFS_DIRCLR: dir_q <= dir_q & ~PIN_COUNT'(merge_lanes('0, PWDATA, PSTRB));
          default:    dir_q <= dir_q;
        endcase
      end
    end
  end

  // ****************************************************************
  // pin setup
  // ****************************************************************
  // only RST resets the setup, loading RST_PIN_SETUP; power states leave it untouched
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        setup_q[i] <= setup_from_word(RST_PIN_SETUP); // RL1 RL20
      end
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (wr_done && setup_hit && (32'(setup_idx) == i)) begin
          setup_q[i] <= setup_from_word(merge_lanes(setup_to_word(setup_q[i]),
                                                    PWDATA, PSTRB)); // RL2
        end else if (wr_done && (PADDR == OFS_DIR || PADDR == OFS_DIRSET
                                 || PADDR == OFS_DIRCLR)) begin
          setup_q[i].dir <= dir_d_bit(i);
        end
      end
    end
  end

  // direction is shared between the port-wide and per-pin views
  function automatic logic dir_d_bit(input int i);
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] f;
    logic              b;
    w = merge_lanes('0, PWDATA, PSTRB);
    f = merge_lanes(32'(dir_q), PWDATA, PSTRB);
    case (PADDR)
      OFS_DIR:    b = f[i];
      OFS_DIRSET: b = dir_q[i] | w[i];
      OFS_DIRCLR: b = dir_q[i] & ~w[i];
      default:    b = dir_q[i];
    endcase
    return b;
  endfunction

  // ****************************************************************
  // match source selector
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      src_q <= SRC_MERGED;
    end else if (wr_done && PADDR == OFS_MATCH_SRC && PSTRB[0]) begin
      src_q <= PWDATA[0] ? SRC_LATCHED : SRC_MERGED; // RL17
    end
  end

  // ****************************************************************
  // sticky match register
  // ****************************************************************
  always_comb begin
    latch_clr = '0;
    if (wr_done && PADDR == OFS_MATCH_LATCH) begin
      latch_clr = PIN_COUNT'(merge_lanes('0, PWDATA, PSTRB)); // RL13
    end
    // a live flag re-sets its bit, so set wins over a clear
    latch_d = (latch_q & ~latch_clr) | det; // RL11 RL12 RL13
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d; // RL11
    end
  end

  // a clear that leaves bits standing drops the signal for one cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clr_seen_q <= 1'b0;
      latched_match_signal_q  <= 1'b0;
    end else begin
      clr_seen_q <= wr_done && PADDR == OFS_MATCH_LATCH;  // RL15
      latched_match_signal_q  <= (|latch_q) & ~clr_seen_q;             // RL14 RL15
    end
  end

  // ****************************************************************
  // port match, event and wake
  // ****************************************************************
  assign port_match_d = (src_q == SRC_LATCHED) ? latched_match_signal_q : merged; // RL17 RL5 RL7

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PORT_MATCH <= 1'b0;
      PORT_EVENT <= 1'b0;
      WAKE_REQ   <= 1'b0;
    end else begin
      PORT_MATCH <= port_match_d;                // RL7
      PORT_EVENT <= port_match_d & ~PORT_MATCH;  // RL8
      WAKE_REQ   <= port_match_d & SYS_OFF;      // RL10 RL6
    end
  end

  // ****************************************************************
  // pad control
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PIN_OUT         <= '0;
      PIN_OE_N        <= '1;
      PIN_PULLUP_EN   <= '0;
      PIN_PULLDOWN_EN <= '0;
      PIN_DRIVE       <= '0;
      PIN_BUF_DISC    <= '1;
      PIN_ANALOG_EN   <= '0;
      PERIPH_IN       <= '0;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        PIN_OUT[i]         <= OVR_EN[i] ? OVR_OUT[i] : out_q[i];        // RL19
        PIN_OE_N[i]        <= ~(OVR_EN[i] ? OVR_DIR[i] : dir_q[i]);     // RL19
        PIN_PULLUP_EN[i]   <= setup_q[i].pull == PULL_UP;
        PIN_PULLDOWN_EN[i] <= setup_q[i].pull == PULL_DOWN;
        PIN_DRIVE[i]       <= setup_q[i].drive;
        PIN_BUF_DISC[i]    <= ~connected[i];                            // RL18
        PIN_ANALOG_EN[i]   <= OVR_EN[i] ? OVR_ANALOG[i] : setup_q[i].analog; // RL19
        PERIPH_IN[i]       <= pin_sync_q[i] & connected[i];             // RL19
      end
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = ready_q;
  assign PSLVERR = pslverr_q;

endmodule

// ===== verif/pin_sense_chk.sv
`timescale 1ns/1ns
// ****************************************************************
// port-side checker for the sense and override paths
// ****************************************************************
module pin_sense_chk #(
  parameter int PIN_COUNT = 32
) (
  input wire logic                 CLK,
  input wire logic                 RST,
  input wire logic [PIN_COUNT-1:0] PIN_OUT,
  input wire logic [PIN_COUNT-1:0] PIN_OE_N,
  input wire logic [PIN_COUNT-1:0] PIN_BUF_DISC,
  input wire logic [PIN_COUNT-1:0] PIN_ANALOG_EN,
  input wire logic [PIN_COUNT-1:0] OVR_EN,
  input wire logic [PIN_COUNT-1:0] OVR_OUT,
  input wire logic [PIN_COUNT-1:0] OVR_DIR,
  input wire logic [PIN_COUNT-1:0] OVR_ANALOG,
  input wire logic [PIN_COUNT-1:0] PERIPH_IN,
  input wire logic                 SYS_OFF,
  input wire logic                 PORT_MATCH,
  input wire logic                 PORT_EVENT,
  input wire logic                 WAKE_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  property p_event_rise; PORT_EVENT |-> PORT_MATCH && !$past(PORT_MATCH); endproperty
  a_event_rise: assert property (p_event_rise) else $error("event without match rise");
  property p_rise_event; $rose(PORT_MATCH) |-> PORT_EVENT; endproperty
  a_rise_event: assert property (p_rise_event) else $error("match rose without event");
  property p_event_pulse; PORT_EVENT |=> !PORT_EVENT; endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event longer than one cycle");
  // wake may be registered, so only a settled match in off state must wake
  property p_wake; PORT_MATCH && SYS_OFF && $past(PORT_MATCH) && $past(SYS_OFF) |-> WAKE_REQ;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on match in off state");
  property p_no_wake; !SYS_OFF && !$past(SYS_OFF) |-> !WAKE_REQ; endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake while system active");
  // both flops load from the same cycle's buffer state, so compare them side by side
  property p_disc;
    (PERIPH_IN & PIN_BUF_DISC) == '0;
  endproperty
  a_disc: assert property (p_disc) else $error("input seen through disconnected buffer");
  property p_ovr_out; ($past(OVR_EN) & (PIN_OUT ^ $past(OVR_OUT))) == '0; endproperty
  a_ovr_out: assert property (p_ovr_out) else $error("override output ignored");
  property p_ovr_dir; ($past(OVR_EN) & (PIN_OE_N ^ ~$past(OVR_DIR))) == '0; endproperty
  a_ovr_dir: assert property (p_ovr_dir) else $error("override direction ignored");
  property p_ovr_ana; ($past(OVR_EN) & (PIN_ANALOG_EN ^ $past(OVR_ANALOG))) == '0; endproperty
  a_ovr_ana: assert property (p_ovr_ana) else $error("override analog ignored");
endmodule

bind pin_level_sense_latch pin_sense_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (
  .CLK(CLK), .RST(RST), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PIN_BUF_DISC(PIN_BUF_DISC),
  .PIN_ANALOG_EN(PIN_ANALOG_EN), .OVR_EN(OVR_EN), .OVR_OUT(OVR_OUT), .OVR_DIR(OVR_DIR),
  .OVR_ANALOG(OVR_ANALOG), .PERIPH_IN(PERIPH_IN), .SYS_OFF(SYS_OFF),
  .PORT_MATCH(PORT_MATCH), .PORT_EVENT(PORT_EVENT), .WAKE_REQ(WAKE_REQ));

// ===== verif/pin_board.sv
`timescale 1ns/1ns
// ****************************************************************
// board side: pad level from all drivers
// ****************************************************************
module pin_board (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] oe_n,
  input  wire logic [31:0] pu,
  input  wire logic [31:0] pd,
  input  wire logic [31:0] lvl,
  input  wire logic [31:0] drv_en,
  output logic      [31:0] pad
);
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!oe_n[i]) pad[i] = pin_out[i];
      else if (drv_en[i]) pad[i] = lvl[i];
      else if (pu[i]) pad[i] = 1'b1;
      else if (pd[i]) pad[i] = 1'b0;
      // floating pad: never let the simulator settle it to a friendly value
      else pad[i] = ~lvl[i];
    end
  end
endmodule

// ===== verif/pin_level_sense_latch_tb.sv
`timescale 1ns/1ns
module pin_level_sense_latch_tb;
  import pin_sense_pkg::*;
  typedef struct { int p; logic [1:0] s; logic l; logic m; } row_s;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic              sys_off, port_match, port_event, wake_req;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic [31:0]       pin_in, pin_out, oe_n, pu, pd, disc, ana, per_in, lvl, xen;
  logic [31:0]       ovr_en, ovr_out, ovr_dir, ovr_ana;
  logic [31:0][2:0]  drv;
  int                error_cnt, checks_done, cyc, ev_cnt, e0;
  row_s              rows[6] = '{'{0, SENSE_HIGH, 1'b1, 1'b1}, '{5, SENSE_LOW, 1'b0, 1'b1},
    '{31, SENSE_HIGH, 1'b0, 1'b0}, '{7, SENSE_OFF, 1'b1, 1'b0},
    '{3, 2'h1, 1'b1, 1'b0}, '{9, SENSE_LOW, 1'b1, 1'b0}};

  pin_level_sense_latch dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(oe_n),
    .PIN_PULLUP_EN(pu), .PIN_PULLDOWN_EN(pd), .PIN_DRIVE(drv), .PIN_BUF_DISC(disc),
    .PIN_ANALOG_EN(ana), .OVR_EN(ovr_en), .OVR_OUT(ovr_out), .OVR_DIR(ovr_dir),
    .OVR_ANALOG(ovr_ana), .PERIPH_IN(per_in), .SYS_OFF(sys_off), .PORT_MATCH(port_match),
    .PORT_EVENT(port_event), .WAKE_REQ(wake_req));
  pin_board u_board (.pin_out(pin_out), .oe_n(oe_n), .pu(pu), .pd(pd), .lvl(lvl),
    .drv_en(xen), .pad(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (port_event === 1'b1) ev_cnt++;
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  function automatic logic [ADDR_W-1:0] cfg(int p);
    return OFS_PIN_SETUP + ADDR_W'(4 * p);
  endfunction

  function automatic logic [31:0] sw(logic [1:0] s);
    return {14'h0, s, 16'h0};
  endfunction

  // entered just after a rising edge; request held until pready is sampled
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives psel in this step
    @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    {rst, psel, penable, pwrite, sys_off} = 5'h10;
    {paddr, pwdata, lvl, ovr_en, ovr_out, ovr_dir, ovr_ana} = '0;
    pstrb = 4'hf;
    xen = '1;
    repeat (10) @(posedge clk);
    chk(oe_n, 32'hffffffff);
    chk(disc, 32'hffffffff);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, cfg(0), 32'h0);
    chk(rd, RST_PIN_SETUP);
    apb(1'b0, 12'h600, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      lvl[rows[i].p] <= rows[i].l;
      e0 = ev_cnt;
      apb(1'b1, cfg(rows[i].p), sw(rows[i].s));
      settle();
      chk({31'h0, port_match}, {31'h0, rows[i].m});
      chk(ev_cnt - e0, {31'h0, rows[i].m});
      apb(1'b0, OFS_MATCH_LATCH, 32'h0);
      chk(rd, {31'h0, rows[i].m} << rows[i].p);
      apb(1'b1, cfg(rows[i].p), 32'h0);
      apb(1'b1, OFS_MATCH_LATCH, 32'hffffffff);
      lvl[rows[i].p] <= 1'b0;
      $display("row %0d done", i);
    end
    apb(1'b1, cfg(2), sw(SENSE_HIGH));
    lvl[2] <= 1'b1;
    settle();
    apb(1'b1, OFS_MATCH_LATCH, 32'h4);
    apb(1'b0, OFS_MATCH_LATCH, 32'h0);
    chk(rd, 32'h4);
    lvl[2] <= 1'b0;
    settle();
    chk({31'h0, port_match}, 32'h0);
    apb(1'b0, OFS_MATCH_LATCH, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, OFS_MATCH_LATCH, 32'h4);
    apb(1'b0, OFS_MATCH_LATCH, 32'h0);
    chk(rd, 32'h0);
    $display("sticky test done");
    apb(1'b1, cfg(4), sw(SENSE_HIGH));
    apb(1'b1, OFS_MATCH_SRC, 32'h1);
    lvl <= 32'h14;
    settle();
    lvl <= 32'h0;
    settle();
    chk({31'h0, port_match}, 32'h1);
    e0 = ev_cnt;
    apb(1'b1, OFS_MATCH_LATCH, 32'h4);
    settle();
    chk(ev_cnt - e0, 32'h1);
    chk({31'h0, port_match}, 32'h1);
    apb(1'b1, OFS_MATCH_LATCH, 32'h10);
    settle();
    chk({31'h0, port_match}, 32'h0);
    apb(1'b1, OFS_MATCH_SRC, 32'h0);
    $display("latched test done");
    apb(1'b1, cfg(2), sw(SENSE_HIGH) | 32'h2);
    lvl[2] <= 1'b1;
    settle();
    chk({31'h0, port_match}, 32'h0);
    chk({31'h0, per_in[2]}, 32'h0);
    sys_off <= 1'b1;
    lvl[4] <= 1'b1;
    settle();
    chk({31'h0, port_match}, 32'h1);
    chk({31'h0, wake_req}, 32'h1);
    sys_off <= 1'b0;
    lvl[4] <= 1'b0;
    {ovr_en[1], ovr_out[1], ovr_dir[1]} <= 3'h7;
    settle();
    chk({31'h0, pin_out[1]}, 32'h1);
    chk({31'h0, oe_n[1]}, 32'h0);
    chk({31'h0, per_in[1]}, 32'h1);
    $display("disconnect, off and override test done");
    apb(1'b1, cfg(6), 32'h0000_051d);
    settle();
    chk({31'h0, pu[6]}, 32'h1);
    chk({31'h0, pd[6]}, 32'h0);
    chk({29'h0, drv[6]}, 32'h5);
    chk({31'h0, ana[6]}, 32'h1);
    chk({31'h0, oe_n[6]}, 32'h0);
    apb(1'b0, OFS_DIR, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, OFS_OUTSET, 32'h40);
    settle();
    chk({31'h0, pin_out[6]}, 32'h1);
    apb(1'b1, OFS_OUTCLR, 32'h40);
    apb(1'b0, OFS_OUT, 32'h0);
    chk(rd, 32'h0);
    $display("pad setup test done");
    wrap_up();
  end
endmodule
